// File: cpdbx_pkg.sv
/*
 Constants shared by the divide, loop and branch execution unit:
 register offsets, flag word layout, opcodes, state counts.
 Assumes a byte-addressed classic Wishbone bus with 32-bit data.
*/
package cpdbx_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_OPCODE = 8'h04;
   localparam logic [7:0] OFS_OPA = 8'h08;
   localparam logic [7:0] OFS_OPB = 8'h0c;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_PC = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   // Control bit: start execution
   localparam int CTRL_GO = 0;
   // Processor flags word bit positions
   localparam int FLG_ROUND = 0;
   localparam int FLG_C = 3;
   localparam int FLG_TRAP = 4;
   localparam int FLG_V = 5;
   localparam int FLG_N = 6;
   localparam int FLG_Z = 7;
   localparam int FLG_IE = 9;
   // Status bit positions
   localparam int STS_BUSY = 0;
   localparam int STS_DONE = 1;
   localparam int STS_TAKEN = 2;
   localparam int STS_ILL = 3;
   localparam int STS_HOLD = 4;
   localparam int STS_LEN = 8;
   localparam int STS_STATES = 16;
   // Reset values
   localparam logic [15:0] FLAGS_RST = 16'h0000;
   localparam logic [15:0] PC_RST = 16'h0000;
   // Opcodes and opcode masks
   localparam logic [7:0] MASK_AA = 8'hfc;
   localparam logic [7:0] MASK_BIT = 8'hf8;
   localparam logic [7:0] OP_UDIV_B = 8'h9c;
   localparam logic [7:0] OP_LOOP = 8'he0;
   localparam logic [7:0] OP_INT_ALLOW = 8'hfb;
   localparam logic [7:0] OP_WIDEN_W = 8'h06;
   localparam logic [7:0] OP_WIDEN_B = 8'h16;
   localparam logic [7:0] OP_INC = 8'h0f;
   localparam logic [7:0] OP_PLUS1_B = 8'h17;
   localparam logic [7:0] OP_BIT_ZERO = 8'h30;
   localparam logic [7:0] OP_BIT_ONE = 8'h38;
   localparam logic [7:0] OP_BR_CARRY = 8'hdb;
   localparam logic [7:0] OP_BR_EQUAL = 8'hdf;
   localparam logic [7:0] OP_BR_SGE = 8'hd6;
   localparam logic [7:0] OP_BR_SGT = 8'hd2;
   localparam logic [7:0] OP_BR_UHI = 8'hd9;
   localparam logic [7:0] OP_BR_SLE = 8'hda;
   // Lengths in bytes
   localparam logic [3:0] LEN_ONE = 4'h1;
   localparam logic [3:0] LEN_TWO = 4'h2;
   localparam logic [3:0] LEN_THREE = 4'h3;
   // State counts, one state per clock
   localparam logic [7:0] CNT_DIV = 8'h11;
   localparam logic [7:0] CNT_LOOP_NT = 8'h05;
   localparam logic [7:0] CNT_LOOP_T = 8'h09;
   localparam logic [7:0] CNT_SHORT_NT = 8'h04;
   localparam logic [7:0] CNT_SHORT_T = 8'h08;
   localparam logic [7:0] CNT_BASIC = 8'h04;
   localparam logic [7:0] CNT_ILL = 8'h01;
   // Addressing-mode extras indexed by the low two opcode bits
   localparam logic [15:0] MODE_EXTRA_BYTES = 16'h1010;
   localparam logic [15:0] MODE_EXTRA_STATES = 16'h3210;
   // Sequencer states
   typedef enum logic [1:0] {
      CPDBX_IDLE = 2'b01,
      CPDBX_RUN = 2'b10
   } cpdbx_state_t;
endpackage : cpdbx_pkg

// File: cpdbx_div.sv
/*
 Unsigned 16 by 8 divide with overflow detection.
 Assumes its inputs are stable while the caller samples the outputs.
*/
`timescale 1ns/10ps
module cpdbx_div (
   input wire logic [15:0] dividend_i,
   input wire logic [7:0] divisor_i,
   output logic [7:0] quot_o,
   output logic [7:0] rem_o,
   output logic ovf_o
);
   import cpdbx_pkg::*;
   logic [15:0] q_full; // Full-width quotient
   logic [15:0] r_full; // Full-width remainder

   ////////////////////////////////////////////////////////////////////
   // Quotient and remainder both from the original dividend
   always_comb begin
      if (divisor_i == 8'h00) begin
         q_full = 16'hffff;
         r_full = 16'h0000;
      end else begin
         q_full = dividend_i / {8'h00, divisor_i};
         r_full = dividend_i % {8'h00, divisor_i};
      end
      quot_o = q_full[7:0];
      rem_o = r_full[7:0];
      // Quotient must fit one byte
      ovf_o = (q_full[15:8] != 8'h00);
   end
endmodule : cpdbx_div

// File: cpdbx_cond.sv
/*
 Branch condition decode for the bit-test and flag-conditioned jumps.
 Assumes the flag inputs are the flags standing before the jump.
*/
`timescale 1ns/10ps
module cpdbx_cond (
   input wire logic [7:0] op_i,
   input wire logic [15:0] flags_i,
   input wire logic [7:0] test_byte_i,
   output logic bit_jump_o,
   output logic short_jump_o,
   output logic take_o
);
   import cpdbx_pkg::*;
   logic z; // Zero flag
   logic n; // Negative flag
   logic c; // Carry flag
   logic tbit; // Selected register bit

   ////////////////////////////////////////////////////////////////////
   // Condition select
   always_comb begin
      z = flags_i[FLG_Z];
      n = flags_i[FLG_N];
      c = flags_i[FLG_C];
      // RQ10 bit number from opcode
      tbit = test_byte_i[op_i[2:0]];
      bit_jump_o = 1'b0;
      short_jump_o = 1'b1;
      take_o = 1'b0;
      if ((op_i & MASK_BIT) == OP_BIT_ZERO) begin
         // RQ10 jump on bit clear
         bit_jump_o = 1'b1;
         short_jump_o = 1'b0;
         take_o = ~tbit;
      end else if ((op_i & MASK_BIT) == OP_BIT_ONE) begin
         // RQ11 jump on bit set
         bit_jump_o = 1'b1;
         short_jump_o = 1'b0;
         take_o = tbit;
      end else begin
         case (op_i)
            // RQ12 carry set
            OP_BR_CARRY: take_o = c;
            // RQ13 zero set
            OP_BR_EQUAL: take_o = z;
            // RQ14 negative clear
            OP_BR_SGE: take_o = ~n;
            // RQ15 negative and zero clear
            OP_BR_SGT: take_o = ~n & ~z;
            // RQ16 carry set, zero clear
            OP_BR_UHI: take_o = c & ~z;
            // RQ17 negative or zero set
            OP_BR_SLE: take_o = n | z;
            default: short_jump_o = 1'b0;
         endcase
      end
   end
endmodule : cpdbx_cond

// File: cpdbx_exec.sv
/*
 Execution unit for byte divide, loop, interrupt enable, sign
 extension, increment and conditional relative jumps.
 Assumes software loads opcode bytes and operands over classic
 Wishbone, starts the unit, and reads the results back.
*/
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
// How it works
// RQ1: Divide word by byte, quotient low, remainder high
// RQ2: Divide concurrent, 17 states plus extra, V, trap
// RQ3: Loop decrements byte, jumps while result nonzero
// RQ4: Loop is three bytes, 5/9 states, flags kept
// RQ5: Enable sets IE, blocks interrupts one instruction
// RQ6: Word widen fills high word, Z N, clears C V
// RQ7: Byte widen fills high byte, Z N, clears C V
// RQ8: Word increment updates Z N C V, trap sticky
// RQ9: Byte increment updates Z N C V, trap sticky
// RQ10: Jump when selected register bit is zero
// RQ11: Jump when selected register bit is one
// RQ12: Jump when carry set
// RQ13: Jump when zero set
// RQ14: Jump when negative clear
// RQ15: Jump when negative and zero clear
// RQ16: Jump when carry set and zero clear
// RQ17: Jump when negative or zero set
// RQ18: Short jumps two bytes, 4/8 states, sign-extended
// RQ19: Mode bits add extra bytes and states
`timescale 1ns/10ps
module cpdbx_exec (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic busy_o,
   output logic int_allow_o
);
   import cpdbx_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Helper functions
   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            m[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   // Byte divide opcode match
   function automatic logic is_div(input logic [7:0] op);
      return (op & MASK_AA) == OP_UDIV_B;
   endfunction : is_div

   ////////////////////////////////////////////////////////////////////
   // Registers
   cpdbx_state_t state_r; // Sequencer state
   logic ack_r; // Bus acknowledge
   logic [31:0] dat_r; // Read data
   logic [23:0] opc_r; // Opcode, register byte, displacement
   logic [31:0] opa_r; // Destination operand
   logic [7:0] opb_r; // Divide source byte
   logic [15:0] flags_r; // Processor flags word
   logic [15:0] pc_r; // Program counter
   logic [7:0] cnt_r; // States left
   logic [31:0] res_a_r; // Pending destination
   logic [15:0] res_f_r; // Pending flags
   logic [15:0] res_pc_r; // Pending program counter
   logic [7:0] states_r; // State count of last start
   logic [3:0] len_r; // Length of last instruction
   logic take_r; // Jump taken
   logic ill_r; // Unknown opcode
   logic hset_r; // Instruction is an enable
   logic hold_r; // Interrupt call held off
   logic done_r; // Completion seen
   logic busy_r; // Busy output
   logic allow_r; // Interrupt allow output

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   logic req; // Request in progress
   logic wr_ev; // Write takes effect this edge
   logic go_acc; // Start accepted
   logic commit; // Last state of execution
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_ev = req & wb_we_i & ack_r;
   assign go_acc = wr_ev & (wb_adr_i == OFS_CTRL) & wb_sel_i[0] &
                   wb_dat_i[CTRL_GO] & (state_r == CPDBX_IDLE);
   assign commit = (state_r == CPDBX_RUN) & (cnt_r == 8'h00);

   ////////////////////////////////////////////////////////////////////
   // Submodules
   logic [7:0] dv_q; // Quotient
   logic [7:0] dv_r; // Remainder
   logic dv_ovf; // Divide overflow
   logic bit_jump; // Bit-test jump
   logic short_jump; // Flag jump
   logic cond_take; // Condition met

   cpdbx_div u_div (
      .dividend_i(opa_r[15:0]),
      .divisor_i(opb_r),
      .quot_o(dv_q),
      .rem_o(dv_r),
      .ovf_o(dv_ovf)
   );

   cpdbx_cond u_cond (
      .op_i(opc_r[7:0]),
      .flags_i(flags_r),
      .test_byte_i(opa_r[7:0]),
      .bit_jump_o(bit_jump),
      .short_jump_o(short_jump),
      .take_o(cond_take)
   );

   ////////////////////////////////////////////////////////////////////
   // Instruction decode and result
   logic [7:0] op; // Opcode
   logic [1:0] aa; // Addressing mode bits
   logic [3:0] len_nxt; // Length in bytes
   logic [7:0] st_nxt; // State count
   logic [31:0] a_nxt; // New destination
   logic [15:0] f_nxt; // New flags
   logic [15:0] pc_nxt; // New program counter
   logic take_nxt; // Jump taken
   logic ill_nxt; // Unknown opcode
   logic hset_nxt; // Enable instruction
   logic [16:0] sum_w; // Word increment with carry
   logic [8:0] sum_b; // Byte increment with carry
   logic [7:0] dec_b; // Loop count after decrement
   logic [15:0] pc_after; // Address after instruction

   always_comb begin
      op = opc_r[7:0];
      aa = op[1:0];
      len_nxt = LEN_TWO;
      st_nxt = CNT_BASIC;
      a_nxt = opa_r;
      f_nxt = flags_r;
      take_nxt = 1'b0;
      ill_nxt = 1'b0;
      hset_nxt = 1'b0;
      sum_w = {1'b0, opa_r[15:0]} + 17'h00001;
      sum_b = {1'b0, opa_r[7:0]} + 9'h001;
      dec_b = opa_r[7:0] - 8'h01;
      if (is_div(op)) begin
         // RQ19 mode extras added
         len_nxt = LEN_TWO + MODE_EXTRA_BYTES[aa*4 +: 4];
         st_nxt = CNT_DIV + {4'h0, MODE_EXTRA_STATES[aa*4 +: 4]};
         // RQ1 quotient low, remainder high
         if (!dv_ovf) begin
            a_nxt[15:0] = {dv_r, dv_q};
         end
         // RQ2 overflow sets V, trap sticky
         f_nxt[FLG_V] = dv_ovf;
         f_nxt[FLG_TRAP] = flags_r[FLG_TRAP] | dv_ovf;
      end else if (bit_jump || short_jump) begin
         // RQ18 short jump length and states
         take_nxt = cond_take;
         len_nxt = bit_jump ? LEN_THREE : LEN_TWO;
         if (bit_jump) begin
            st_nxt = cond_take ? CNT_LOOP_T : CNT_LOOP_NT;
         end else begin
            st_nxt = cond_take ? CNT_SHORT_T : CNT_SHORT_NT;
         end
      end else begin
         case (op)
            OP_LOOP: begin
               // RQ3 decrement, jump if nonzero
               a_nxt[7:0] = dec_b;
               take_nxt = (dec_b != 8'h00);
               // RQ4 three bytes, 5 or 9 states
               len_nxt = LEN_THREE;
               st_nxt = take_nxt ? CNT_LOOP_T : CNT_LOOP_NT;
            end
            OP_INT_ALLOW: begin
               // RQ5 set interrupt enable
               len_nxt = LEN_ONE;
               f_nxt[FLG_IE] = 1'b1;
               hset_nxt = 1'b1;
            end
            OP_WIDEN_W: begin
               // RQ6 widen word into high word
               a_nxt[31:16] = opa_r[15] ? 16'hffff : 16'h0000;
               f_nxt[FLG_Z] = (a_nxt == 32'h00000000);
               f_nxt[FLG_N] = a_nxt[31];
               f_nxt[FLG_C] = 1'b0;
               f_nxt[FLG_V] = 1'b0;
            end
            OP_WIDEN_B: begin
               // RQ7 widen byte into high byte
               a_nxt[15:8] = opa_r[7] ? 8'hff : 8'h00;
               f_nxt[FLG_Z] = (a_nxt[15:0] == 16'h0000);
               f_nxt[FLG_N] = a_nxt[15];
               f_nxt[FLG_C] = 1'b0;
               f_nxt[FLG_V] = 1'b0;
            end
            OP_INC: begin
               // RQ8 word increment flags
               a_nxt[15:0] = sum_w[15:0];
               f_nxt[FLG_Z] = (sum_w[15:0] == 16'h0000);
               f_nxt[FLG_N] = sum_w[15];
               f_nxt[FLG_C] = sum_w[16];
               f_nxt[FLG_V] = (opa_r[15:0] == 16'h7fff);
               f_nxt[FLG_TRAP] = flags_r[FLG_TRAP] | f_nxt[FLG_V];
            end
            OP_PLUS1_B: begin
               // RQ9 byte increment flags
               a_nxt[7:0] = sum_b[7:0];
               f_nxt[FLG_Z] = (sum_b[7:0] == 8'h00);
               f_nxt[FLG_N] = sum_b[7];
               f_nxt[FLG_C] = sum_b[8];
               f_nxt[FLG_V] = (opa_r[7:0] == 8'h7f);
               f_nxt[FLG_TRAP] = flags_r[FLG_TRAP] | f_nxt[FLG_V];
            end
            default: begin
               // Unknown opcode changes nothing
               ill_nxt = 1'b1;
               len_nxt = LEN_ONE;
               st_nxt = CNT_ILL;
            end
         endcase
      end
      // RQ18 displacement sign-extended to 16 bits
      pc_after = pc_r + {12'h000, len_nxt};
      pc_nxt = ill_nxt ? pc_r : pc_after;
      if (take_nxt) begin
         pc_nxt = pc_after + {{8{opc_r[23]}}, opc_r[23:16]};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer: one state per clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= CPDBX_IDLE;
         cnt_r <= 8'h00;
         busy_r <= 1'b0;
      end else begin
         case (state_r)
            CPDBX_IDLE: begin
               if (go_acc) begin
                  state_r <= CPDBX_RUN;
                  cnt_r <= st_nxt - 8'h01;
                  busy_r <= 1'b1;
               end
            end
            CPDBX_RUN: begin
               if (commit) begin
                  state_r <= CPDBX_IDLE;
                  busy_r <= 1'b0;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            default: begin
               state_r <= CPDBX_IDLE;
               busy_r <= 1'b0;
            end
         endcase
      end
   end

   // Pending results captured at start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_a_r <= 32'h00000000;
         res_f_r <= FLAGS_RST;
         res_pc_r <= PC_RST;
         states_r <= 8'h00;
         len_r <= 4'h0;
         take_r <= 1'b0;
         ill_r <= 1'b0;
         hset_r <= 1'b0;
      end else if (go_acc) begin
         res_a_r <= a_nxt;
         res_f_r <= f_nxt;
         res_pc_r <= pc_nxt;
         states_r <= st_nxt;
         len_r <= len_nxt;
         take_r <= take_nxt;
         ill_r <= ill_nxt;
         hset_r <= hset_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Architectural state: commit wins over a bus write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         opa_r <= 32'h00000000;
      end else if (commit) begin
         opa_r <= res_a_r;
      end else if (wr_ev && wb_adr_i == OFS_OPA) begin
         opa_r <= merge(opa_r, wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_r <= FLAGS_RST;
      end else if (commit) begin
         flags_r <= res_f_r;
      end else if (wr_ev && wb_adr_i == OFS_FLAGS) begin
         flags_r <= 16'(merge({16'h0000, flags_r}, wb_dat_i, wb_sel_i));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_r <= PC_RST;
      end else if (commit) begin
         pc_r <= res_pc_r;
      end else if (wr_ev && wb_adr_i == OFS_PC) begin
         pc_r <= 16'(merge({16'h0000, pc_r}, wb_dat_i, wb_sel_i));
      end
   end

   // Operand loads, held during execution
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         opc_r <= 24'h000000;
         opb_r <= 8'h00;
      end else if (wr_ev && state_r == CPDBX_IDLE) begin
         if (wb_adr_i == OFS_OPCODE) begin
            opc_r <= 24'(merge({8'h00, opc_r}, wb_dat_i, wb_sel_i));
         end
         if (wb_adr_i == OFS_OPB && wb_sel_i[0]) begin
            opb_r <= wb_dat_i[7:0];
         end
      end
   end

   // Completion and interrupt hold-off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_r <= 1'b0;
         hold_r <= 1'b0;
         allow_r <= 1'b0;
      end else begin
         if (commit) begin
            done_r <= 1'b1;
         end else if (go_acc) begin
            done_r <= 1'b0;
         end
         // RQ5 hold lasts through next instruction
         if (commit) begin
            hold_r <= hset_r;
         end
         allow_r <= flags_r[FLG_IE] & ~hold_r & ~(commit & hset_r);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Wishbone answer, one wait state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else begin
         ack_r <= req & ~ack_r;
         if (req && !ack_r) begin
            case (wb_adr_i)
               OFS_OPCODE: dat_r <= {8'h00, opc_r};
               OFS_OPA: dat_r <= opa_r;
               OFS_OPB: dat_r <= {24'h000000, opb_r};
               OFS_FLAGS: dat_r <= {16'h0000, flags_r};
               OFS_PC: dat_r <= {16'h0000, pc_r};
               OFS_STATUS: dat_r <= {8'h00, states_r, 4'h0, len_r, 3'h0,
                                     hold_r, ill_r, take_r, done_r, busy_r};
               default: dat_r <= 32'h00000000;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign busy_o = busy_r;
   assign int_allow_o = allow_r;

   ////////////////////////////////////////////////////////////////////
   // Checks
   logic [7:0] run_len_r; // Busy cycles counted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_len_r <= 8'h00;
      end else begin
         run_len_r <= busy_r ? run_len_r + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_single: assert property (ack_r |=> !ack_r)
      else $error("ack held longer than one cycle");
   a_busy_length: assert property ($fell(busy_r) |-> run_len_r == states_r) // RQ18
      else $error("busy length differs from state count");
   a_div_states: assert property (go_acc && is_div(opc_r[7:0]) |=> // RQ19
      states_r == CNT_DIV + {4'h0, MODE_EXTRA_STATES[$past(opc_r[1:0])*4 +: 4]})
      else $error("divide state count wrong");
   a_div_math: assert property (go_acc && is_div(opc_r[7:0]) && // RQ1
      opb_r != 8'h00 && opa_r[15:8] < opb_r |=>
      ({8'h00, res_a_r[7:0]} * {8'h00, $past(opb_r)} + {8'h00, res_a_r[15:8]})
      == $past(opa_r[15:0]))
      else $error("divide result does not rebuild dividend");
   a_div_sticky: assert property (go_acc && is_div(opc_r[7:0]) && // RQ2
      flags_r[FLG_TRAP] |=> res_f_r[FLG_TRAP])
      else $error("divide cleared overflow trap");
   a_loop_branch: assert property (go_acc && opc_r[7:0] == OP_LOOP && // RQ3
      opa_r[7:0] == 8'h01 |=> !take_r && res_pc_r == $past(pc_r) + 16'h0003)
      else $error("loop jumped at zero count");
   a_loop_flags: assert property (go_acc && opc_r[7:0] == OP_LOOP |=> // RQ4
      res_f_r == $past(flags_r) && states_r == (take_r ? CNT_LOOP_T : CNT_LOOP_NT))
      else $error("loop flags or states wrong");
   a_enable_hold: assert property (commit && hset_r |=> // RQ5
      flags_r[FLG_IE] && !allow_r ##1 !allow_r)
      else $error("interrupt allowed right after enable");
   a_widen_word: assert property (go_acc && opc_r[7:0] == OP_WIDEN_W |=> // RQ6
      res_a_r[31:16] == {16{res_a_r[15]}} && !res_f_r[FLG_C] && !res_f_r[FLG_V])
      else $error("word widen wrong");
   a_widen_byte: assert property (go_acc && opc_r[7:0] == OP_WIDEN_B |=> // RQ7
      res_a_r[15:8] == {8{res_a_r[7]}} && res_f_r[FLG_N] == res_a_r[7])
      else $error("byte widen wrong");
   a_inc_wrap: assert property (go_acc && opc_r[7:0] == OP_INC && // RQ8
      opa_r[15:0] == 16'hffff |=> res_a_r[15:0] == 16'h0000 &&
      res_f_r[FLG_C] && res_f_r[FLG_Z])
      else $error("word increment wrap wrong");
   a_byte_inc_ovf: assert property (go_acc && opc_r[7:0] == OP_PLUS1_B && // RQ9
      opa_r[7:0] == 8'h7f |=> res_f_r[FLG_V] && res_f_r[FLG_TRAP] && res_f_r[FLG_N])
      else $error("byte increment overflow wrong");
   a_short_target: assert property (go_acc && short_jump && cond_take |=> // RQ18
      res_pc_r == $past(pc_r) + 16'h0002 + {{8{$past(opc_r[23])}}, $past(opc_r[23:16])})
      else $error("short jump target wrong");

   c_divide: cover property (commit && is_div(opc_r[7:0]));
   c_loop_taken: cover property (commit && take_r && opc_r[7:0] == OP_LOOP);
   c_enable: cover property (commit && hset_r);
   c_jump_taken: cover property (go_acc && short_jump && cond_take);
endmodule : cpdbx_exec

// File: test_cpu_divide_branch_exec.sv
/*
 Bench for the execution unit: loads operands over Wishbone, starts
 each instruction, checks results. Assumes one 20 MHz clock.
*/
`timescale 1ns/10ps
module test_cpu_divide_branch_exec;
   import cpdbx_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [3:0] sel = 0;
   logic [7:0] adr = 0;
   logic [31:0] dat = 0, rdat, q, sts, ra, rf, rp, t, e;
   logic ack, busy, ia;
   int err_count = 0, compares = 0, cyc_count = 0, i, bcnt = 0;
   // Jump table: opcode, flags, operand byte, taken, length
   logic [31:0] tbl [15] = '{32'hdb080012, 32'hdb000002, 32'hdf800012, 32'hdf000002,
      32'hd6000012, 32'hd6400002, 32'hd2000012, 32'hd2800002, 32'hd9080012,
      32'hd9880002, 32'hda400012, 32'hda000002, 32'h33000803, 32'h3b000813,
      32'h3000fe13};
   cpdbx_exec dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .busy_o(busy), .int_allow_o(ia));
   ////////////////////////////////////////////////////////////////////////
   // Clock and hang limit
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_count++;
      // Busy cycles of the current instruction
      if (busy === 1'b1) begin
         bcnt++;
      end
      if (cyc_count == 8000) begin
         err_count++;
         conclude();
      end
   end
   // Verdict and end of run
   task automatic conclude();
      if (err_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   // One classic Wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
      do @(posedge clk_i); while (ack !== 1'b1);
      r = rdat;
      cyc <= 0; stb <= 0;
   endtask : wb
   // Value compare
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   // Load, start, wait idle, read back
   task automatic run(input logic [31:0] o, input logic [31:0] a, input logic [15:0] f,
      input logic [15:0] p);
      wb(1, OFS_OPCODE, o, q); wb(1, OFS_OPA, a, q); wb(1, OFS_OPB, 32'h10, q);
      wb(1, OFS_FLAGS, {16'h0, f}, q); wb(1, OFS_PC, {16'h0, p}, q);
      bcnt = 0;
      wb(1, OFS_CTRL, 32'h1, q);
      do wb(0, OFS_STATUS, 0, sts); while (sts[0] !== 1'b0);
      wb(0, OFS_OPA, 0, ra); wb(0, OFS_FLAGS, 0, rf); wb(0, OFS_PC, 0, rp);
   endtask : run
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      wb(0, 8'h40, 0, q);
      chk("unmapped", 0, q);
      run(32'h9c, 32'h0107, 0, 0);
      chk("quot_rem", 32'h0710, ra);
      chk("div_sts", 32'h00110202, sts & 32'h00ff0f06);
      chk("div_busy", 32'h11, bcnt);
      run(32'h9d, 32'h0107, 0, 0);
      chk("mode_sts", 32'h00120302, sts & 32'h00ff0f06);
      run(32'h9c, 32'h1000, 0, 0);
      chk("div_ovf", 32'h1000, ra);
      chk("div_flg", 32'h30, rf);
      run(32'h00fe05e0, 2, 16'h00a8, 16'h0100);
      chk("loop_t", 32'h00090306, sts & 32'h00ff0f06);
      chk("loop_busy", 32'h9, bcnt);
      chk("loop_pc", 32'h0101, rp);
      chk("loop_flg", 32'ha8, rf);
      run(32'h00fe05e0, 1, 0, 16'h0100);
      chk("loop_nt", 32'h00050302, sts & 32'h00ff0f06);
      chk("loop_cnt", 0, ra);
      chk("loop_nt_pc", 32'h0103, rp);
      run(32'h16, 32'h80, 16'h28, 0);
      chk("byte_widen", 32'hff80, ra & 32'hffff);
      chk("byte_widen_f", 32'h40, rf);
      run(32'h06, 32'h8000, 16'h28, 0);
      chk("word_widen", 32'hffff8000, ra);
      chk("word_widen_f", 32'h40, rf);
      run(32'h0f, 32'h7fff, 0, 0);
      chk("inc", 32'h8000, ra & 32'hffff);
      chk("inc_f", 32'h70, rf);
      run(32'h17, 32'hff, 0, 0);
      chk("byte_inc", 0, ra & 32'hff);
      chk("byte_inc_f", 32'h88, rf);
      run(32'hfb, 0, 0, 0);
      chk("ie_flag", 32'h200, rf);
      chk("ie_hold", 0, {31'h0, ia});
      run(32'hdb, 0, 16'h0200, 0);
      chk("ie_open", 1, {31'h0, ia});
      for (i = 0; i < 15; i++) begin
         t = tbl[i];
         run({16'h0080, 8'h0, t[31:24]}, {24'h0, t[15:8]}, {8'h0, t[23:16]}, 16'h1000);
         e = 32'h1000 + t[3:0] - (t[4] ? 32'h80 : 32'h0);
         chk("jmp_pc", e, rp);
         e = {8'h0, t[3:0] == 4'h3 ? (t[4] ? 8'h9 : 8'h5) : (t[4] ? 8'h8 : 8'h4),
            4'h0, t[3:0], 5'h0, t[4], 2'b10};
         chk("jmp_sts", e, sts & 32'h00ff0f06);
         chk("jmp_busy", {24'h0, e[23:16]}, bcnt);
         chk("jmp_flg", {24'h0, t[23:16]}, rf);
      end
      // Unknown opcode: one state, nothing changes
      run(32'h01, 32'h5a, 16'h0008, 16'h0200);
      chk("ill_sts", 32'h0001010a, sts & 32'h00ff0f0e);
      chk("ill_busy", 32'h1, bcnt);
      chk("ill_pc", 32'h0200, rp);
      chk("ill_opa", 32'h5a, ra);
      conclude();
   end
endmodule : test_cpu_divide_branch_exec
